/* design/pwmcr_pkg.sv */
// package: register offsets, field positions and encodings of the pwm control set
package pwmcr_pkg;
  localparam logic [2:0] ADDR_PULSE_CONTROL  = 3'h0;
  localparam logic [2:0] ADDR_IRQ_ENABLE     = 3'h1;
  localparam logic [2:0] ADDR_IRQ_FLAGS      = 3'h2;
  localparam logic [2:0] ADDR_CLOCK_SELECT   = 3'h3;
  localparam logic [2:0] ADDR_RELOAD_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_OFFSET_CONTROL = 3'h5;
  localparam logic [2:0] ADDR_PERIOD_LO      = 3'h6;
  localparam logic [2:0] ADDR_PERIOD_HI      = 3'h7;

  localparam int EN_BIT      = 7;
  localparam int OUT_BIT     = 5;
  localparam int POL_BIT     = 4;
  localparam int MODE_LSB    = 2;
  localparam int PS_LSB      = 4;
  localparam int CS_LSB      = 0;
  localparam int ARMED_BIT   = 7;
  localparam int TRIG_BIT    = 6;
  localparam int PICK_BIT    = 0;
  localparam int OFM_LSB     = 5;
  localparam int OFO_BIT     = 4;

  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [1:0] CS_RESERVED = 2'h3;

  typedef enum logic [3:0] {
    PWMCR_STANDARD = 4'h1,
    PWMCR_SET      = 4'h2,
    PWMCR_TOGGLE   = 4'h4,
    PWMCR_CENTER   = 4'h8
  } pwmcr_mode_e;

  localparam logic [1:0] MODE_STANDARD = 2'h0;
  localparam logic [1:0] MODE_SET      = 2'h1;
  localparam logic [1:0] MODE_TOGGLE   = 2'h2;
  localparam logic [1:0] MODE_CENTER   = 2'h3;
  localparam logic [1:0] OFM_INDEP     = 2'h0;
  localparam logic [1:0] OFM_SLAVE     = 2'h1;
  localparam logic [1:0] OFM_ONESHOT   = 2'h2;
  localparam logic [1:0] OFM_CONTRESET = 2'h3;
endpackage : pwmcr_pkg

/* design/pwmcr_sync.sv */
// three-stage synchroniser with agreement filter for one external level
module pwmcr_sync (
  // clock
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // level
  input  wire logic async_i,
  output logic      level_o
);
  logic s1;
  logic s2;
  logic s3;

  // s1 feeds only s2; the filter looks at s2 and s3
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule : pwmcr_sync

/* design/pwmcr_top.sv */
// pwm control and status register set with its timer, modes and reload
// Operation
// - enable bit 7 runs the module
// - read-only output state bit 5
// - polarity bit 4 selects active low
// - mode field selects waveform
// - enable bits gate flags onto interrupt
// - flags set on events, software writable
// - flags held clear while disabled
// - prescaler divides by two to field
// - clock source select, 11 reserved
// - internal oscillators keep running in sleep
// - reload copies all buffers at once
// - immediate reload at period end
// - triggered reload at period after trigger
// - armed bit cleared after reload
// - trigger mode waits for trigger
// - offset mode field selects slave behaviour
// - unimplemented bits read zero
// - flags set on rising match edge
// - direction bit double buffered
// - arming at period match dropped
module pwmcr_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // register port
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // clock sources and sleep
  input  wire logic        system_osc_clock_i,
  input  wire logic        high_freq_internal_osc_i,
  input  wire logic        low_freq_internal_osc_i,
  input  wire logic        sleep_i,
  // match values from the buffered count registers
  input  wire logic [15:0] phase_buf_i,
  input  wire logic [15:0] duty_buf_i,
  input  wire logic [15:0] offset_buf_i,
  input  wire logic        buffered_output_control_bit_i,
  // peer events
  input  wire logic        first_module_reload_event_i,
  input  wire logic        second_module_reload_event_i,
  input  wire logic        first_module_offset_event_i,
  input  wire logic        second_module_offset_event_i,
  // outputs
  output logic             pwm_o,
  output logic             irq_o,
  output logic             reload_event_o,
  output logic             offset_event_o,
  output logic             output_control_o,
  output logic [15:0]      pulse_counter_o
);
  logic [7:0]  pulse_control;
  logic [3:0]  irq_enable;
  logic [3:0]  irq_flags;
  logic [6:0]  clock_select;
  logic [1:0]  reload_hi;
  logic        reload_trigger_pick;
  logic [1:0]  offset_run_mode;
  logic        offset_direction_pick;
  logic        offset_source_pick;
  logic        active_direction;
  logic [15:0] period_buf;
  logic [15:0] period_count;
  logic [15:0] phase_act;
  logic [15:0] duty_act;
  logic [15:0] offset_act;
  logic [7:0]  prescale_cnt;
  logic        count_down;
  logic        running;
  logic        trig_seen;
  logic        wave;
  logic [3:0]  match_prev;
  logic        src_tick;
  logic        src_prev;

  // synchronised clock sources and peer events
  logic [6:0] raw_in;
  logic [6:0] syn_in;
  assign raw_in = {system_osc_clock_i, high_freq_internal_osc_i,
                   low_freq_internal_osc_i, first_module_reload_event_i,
                   second_module_reload_event_i, first_module_offset_event_i,
                   second_module_offset_event_i};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      pwmcr_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .async_i (raw_in[gi]),
        .level_o (syn_in[gi])
      );
    end
  endgenerate

  wire enabled     = pulse_control[pwmcr_pkg::EN_BIT];
  wire active_low  = pulse_control[pwmcr_pkg::POL_BIT];
  wire [1:0] mode  = pulse_control[pwmcr_pkg::MODE_LSB +: 2];
  wire [2:0] prescale_field = clock_select[pwmcr_pkg::PS_LSB +: 3];
  wire [1:0] cs    = clock_select[pwmcr_pkg::CS_LSB +: 2];
  wire reload_armed      = reload_hi[1];
  wire reload_on_trigger = reload_hi[0];

  // clock source choice; reserved code gives no ticks
  wire src_level = (cs == 2'h0) ? syn_in[6] :
                   (cs == 2'h1) ? syn_in[5] :
                   (cs == 2'h2) ? syn_in[4] : 1'b0;
  // the system oscillator stops in sleep, internal ones do not
  wire src_live  = (cs == 2'h1) || (cs == 2'h2) || !sleep_i;
  wire src_edge  = src_level && !src_prev && src_live;
  // prescaler: tick when the low bits of the divider wrap
  wire [7:0] ps_mask = 8'(({8'h00, 1'b1} << prescale_field) - 9'h001);
  wire tick = src_edge && ((prescale_cnt & ps_mask) == ps_mask);

  wire reload_trig = reload_trigger_pick ? syn_in[2] : syn_in[3];
  wire offset_in   = offset_source_pick  ? syn_in[0] : syn_in[1];

  wire at_period   = (pulse_counter_o == period_count);
  wire at_zero     = (pulse_counter_o == 16'h0000);
  wire center      = (mode == pwmcr_pkg::MODE_CENTER);
  // period event: end of count; center mode ends on return to zero
  wire period_evt  = tick && running &&
                     (center ? (count_down && at_zero) : at_period);
  wire duty_start  = center ? (!count_down &&
                     pulse_counter_o == period_count - duty_act)
                     : at_zero;
  wire duty_end    = center ? (count_down &&
                     pulse_counter_o == period_count - duty_act + 16'h0001)
                     : (pulse_counter_o == duty_act);
  wire phase_m     = (pulse_counter_o == phase_act);
  wire offset_m    = (pulse_counter_o == offset_act) &&
                     (!center || (count_down != active_direction));
  wire [3:0] match_now = {offset_m, phase_m, duty_end, at_period} &
                         {4{running}};
  // flags follow rising edges of the match levels
  wire [3:0] match_rise = match_now & ~match_prev;

  // arming counts only when the trigger condition holds
  wire load_ready = reload_armed &&
                    (!reload_on_trigger || trig_seen);
  wire do_load    = period_evt && load_ready;

  // offset modes: start and restart of the slave timer
  wire ofs_start  = offset_in && enabled;
  wire may_start  = (offset_run_mode == pwmcr_pkg::OFM_INDEP) ? enabled
                    : ofs_start;
  wire oneshot    = (offset_run_mode == pwmcr_pkg::OFM_ONESHOT);
  wire cont_reset = (offset_run_mode == pwmcr_pkg::OFM_CONTRESET) &&
                    running && offset_in && tick;

  // waveform before polarity
  logic next_wave;
  always_comb begin
    next_wave = wave;
    case (mode)
      pwmcr_pkg::MODE_STANDARD: begin
        if (duty_end) next_wave = 1'b0;
        else if (phase_m) next_wave = 1'b1;
      end
      pwmcr_pkg::MODE_SET: begin
        if (duty_end) next_wave = 1'b1;
      end
      pwmcr_pkg::MODE_TOGGLE: begin
        if (duty_end) next_wave = !wave;
      end
      pwmcr_pkg::MODE_CENTER: begin
        if (duty_start) next_wave = 1'b1;
        else if (duty_end) next_wave = 1'b0;
      end
      default: next_wave = wave;
    endcase
  end

  wire out_state = wave ^ active_low;

  // register writes
  wire wr_pc  = wr_i && addr_i == pwmcr_pkg::ADDR_PULSE_CONTROL;
  wire wr_ie  = wr_i && addr_i == pwmcr_pkg::ADDR_IRQ_ENABLE;
  wire wr_if  = wr_i && addr_i == pwmcr_pkg::ADDR_IRQ_FLAGS;
  wire wr_cs  = wr_i && addr_i == pwmcr_pkg::ADDR_CLOCK_SELECT;
  wire wr_ld  = wr_i && addr_i == pwmcr_pkg::ADDR_RELOAD_CONTROL;
  wire wr_of  = wr_i && addr_i == pwmcr_pkg::ADDR_OFFSET_CONTROL;
  wire wr_plo = wr_i && addr_i == pwmcr_pkg::ADDR_PERIOD_LO;
  wire wr_phi = wr_i && addr_i == pwmcr_pkg::ADDR_PERIOD_HI;

  // hardware set wins over a software clear; disable forces clear
  wire [3:0] flag_sw   = wr_if ? wdata_i[3:0] : irq_flags;
  wire [3:0] next_flags = enabled ? (flag_sw | (match_rise & {4{tick}}))
                          : 4'h0;

  // arming written while timer sits on period is dropped
  wire arm_write = wr_ld && wdata_i[pwmcr_pkg::ARMED_BIT];
  wire arm_late  = arm_write && at_period && running;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_control         <= pwmcr_pkg::RESET_VALUE;
      irq_enable            <= 4'h0;
      irq_flags             <= 4'h0;
      clock_select          <= 7'h00;
      reload_hi             <= 2'h0;
      reload_trigger_pick   <= 1'b0;
      offset_run_mode       <= 2'h0;
      offset_direction_pick <= 1'b0;
      offset_source_pick    <= 1'b0;
      period_buf            <= 16'h0000;
    end else if (ce_i) begin
      irq_flags <= next_flags;
      if (wr_pc) begin
        pulse_control <= {wdata_i[7], 1'b0, 1'b0, wdata_i[4:2], 2'h0};
      end
      if (wr_ie) irq_enable <= wdata_i[3:0];
      if (wr_cs) clock_select <= {wdata_i[6:4], 2'h0, wdata_i[1:0]};
      if (wr_of) begin
        offset_run_mode       <= wdata_i[pwmcr_pkg::OFM_LSB +: 2];
        offset_direction_pick <= wdata_i[pwmcr_pkg::OFO_BIT];
        offset_source_pick    <= wdata_i[pwmcr_pkg::PICK_BIT];
      end
      if (wr_plo) period_buf[7:0]  <= wdata_i;
      if (wr_phi) period_buf[15:8] <= wdata_i;
      if (wr_ld) begin
        reload_hi[0]        <= wdata_i[pwmcr_pkg::TRIG_BIT];
        reload_trigger_pick <= wdata_i[pwmcr_pkg::PICK_BIT];
      end
      // a fresh arming beats the clear of a center-mode load; at the period count it is dropped
      if (wr_ld && !arm_late) begin
        reload_hi[1] <= wdata_i[pwmcr_pkg::ARMED_BIT];
      end else if (do_load) begin
        reload_hi[1] <= 1'b0;
      end
    end
  end

  // timer, waveform and active copies
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_counter_o  <= 16'h0000;
      prescale_cnt     <= 8'h00;
      src_prev         <= 1'b0;
      count_down       <= 1'b0;
      running          <= 1'b0;
      trig_seen        <= 1'b0;
      wave             <= 1'b0;
      match_prev       <= 4'h0;
      period_count     <= 16'h0000;
      phase_act        <= 16'h0000;
      duty_act         <= 16'h0000;
      offset_act       <= 16'h0000;
      output_control_o <= 1'b0;
      active_direction <= 1'b0;
      reload_event_o   <= 1'b0;
      offset_event_o   <= 1'b0;
    end else if (ce_i) begin
      src_prev       <= src_level;
      reload_event_o <= do_load;
      offset_event_o <= tick && match_rise[3];
      if (src_edge) prescale_cnt <= prescale_cnt + 8'h01;
      if (reload_armed && reload_on_trigger && reload_trig) begin
        trig_seen <= 1'b1;
      end else if (do_load || !reload_armed) begin
        trig_seen <= 1'b0;
      end
      if (do_load) begin
        period_count     <= period_buf;
        phase_act        <= phase_buf_i;
        duty_act         <= duty_buf_i;
        offset_act       <= offset_buf_i;
        output_control_o <= buffered_output_control_bit_i;
        active_direction <= offset_direction_pick;
      end
      if (!enabled) begin
        running         <= 1'b0;
        pulse_counter_o <= 16'h0000;
        count_down      <= 1'b0;
        wave            <= 1'b0;
        match_prev      <= 4'h0;
        // idle module takes writes straight through
        period_count     <= period_buf;
        phase_act        <= phase_buf_i;
        duty_act         <= duty_buf_i;
        offset_act       <= offset_buf_i;
        active_direction <= offset_direction_pick;
      end else if (!running) begin
        if (may_start) running <= 1'b1;
      end else if (tick) begin
        match_prev <= match_now;
        wave       <= next_wave;
        if (cont_reset) begin
          pulse_counter_o <= 16'h0001;
        end else if (period_evt || (!center && at_period)) begin
          pulse_counter_o <= 16'h0000;
          count_down      <= 1'b0;
          if (oneshot) running <= 1'b0;
        end else if (center && at_period && !count_down) begin
          count_down      <= 1'b1;
          pulse_counter_o <= pulse_counter_o - 16'h0001;
        end else if (count_down) begin
          pulse_counter_o <= pulse_counter_o - 16'h0001;
        end else begin
          pulse_counter_o <= pulse_counter_o + 16'h0001;
        end
      end
    end
  end

  // read mux; unimplemented positions are zero
  logic [7:0] rd_mux;
  assign rd_mux =
    (addr_i == pwmcr_pkg::ADDR_PULSE_CONTROL)  ?
      {pulse_control[7], 1'b0, out_state, pulse_control[4:2], 2'h0} :
    (addr_i == pwmcr_pkg::ADDR_IRQ_ENABLE)     ? {4'h0, irq_enable} :
    (addr_i == pwmcr_pkg::ADDR_IRQ_FLAGS)      ? {4'h0, irq_flags} :
    (addr_i == pwmcr_pkg::ADDR_CLOCK_SELECT)   ? {1'b0, clock_select} :
    (addr_i == pwmcr_pkg::ADDR_RELOAD_CONTROL) ?
      {reload_hi, 5'h00, reload_trigger_pick} :
    (addr_i == pwmcr_pkg::ADDR_OFFSET_CONTROL) ?
      {1'b0, offset_run_mode, offset_direction_pick, 3'h0,
       offset_source_pick} :
    (addr_i == pwmcr_pkg::ADDR_PERIOD_LO)      ? period_buf[7:0] :
    period_buf[15:8];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      pwm_o   <= 1'b0;
      irq_o   <= 1'b0;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
      pwm_o   <= out_state;
      irq_o   <= |(irq_flags & irq_enable);
    end
  end
endmodule : pwmcr_top

/* dv/pwmcr_peer_model.sv */
// peer pwm modules and clock sources seen by the control block
module pwmcr_peer_model (
  // clock
  input  wire logic clk_i,
  // source clocks
  output logic      sys_osc_o,
  output logic      hf_osc_o,
  output logic      lf_osc_o,
  // peer events
  output logic      first_reload_o,
  output logic      second_reload_o,
  output logic      first_offset_o,
  output logic      second_offset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {sys_osc_o, hf_osc_o, lf_osc_o} = 3'h0;
    {first_reload_o, second_reload_o} = 2'h0;
    {first_offset_o, second_offset_o} = 2'h0;
  end
  // slow edges so the agreement filter never drops one; sources idle low
  task automatic tick(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      {sys_osc_o, hf_osc_o, lf_osc_o} <= 3'h7;
      repeat (4) @(posedge clk_i);
      {sys_osc_o, hf_osc_o, lf_osc_o} <= 3'h0;
    end
    repeat (8) @(posedge clk_i);
  endtask : tick
  // a peer's load or offset event, held long enough to pass the filter
  task automatic fire(input logic [3:0] sel);
    @(posedge clk_i);
    {first_reload_o, second_reload_o, first_offset_o, second_offset_o} <= sel;
    repeat (8) @(posedge clk_i);
    {first_reload_o, second_reload_o, first_offset_o, second_offset_o} <= 4'h0;
  endtask : fire
endmodule : pwmcr_peer_model

/* dv/pwmcr_properties.sv */
// concurrent checks on the pwm control register set ports
module pwmcr_properties (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // register port
  input wire logic [2:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // pulse side
  input wire logic        buffered_output_control_bit_i,
  input wire logic        pwm_o,
  input wire logic        irq_o,
  input wire logic        reload_event_o,
  input wire logic        output_control_o,
  input wire logic [15:0] pulse_counter_o
);
  logic       en_q;
  logic       rd_q;
  logic [2:0] ra_q;
  logic [3:0] ie_q;
  logic [1:0] cs_q;
  // shadows of written fields, so checks can see what software asked for
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {en_q, rd_q, ra_q, ie_q, cs_q} <= '0;
    end else if (ce_i) begin
      rd_q <= rd_i;
      ra_q <= addr_i;
      if (wr_i && addr_i == 3'h0) en_q <= wdata_i[7];
      if (wr_i && addr_i == 3'h1) ie_q <= wdata_i[3:0];
      if (wr_i && addr_i == 3'h3) cs_q <= wdata_i[1:0];
    end
  end
  function automatic logic [7:0] unused_bits(input logic [2:0] a);
    case (a)
      3'h0: unused_bits = 8'h43;
      3'h1, 3'h2: unused_bits = 8'hF0;
      3'h3: unused_bits = 8'h8C;
      3'h4: unused_bits = 8'h3E;
      3'h5: unused_bits = 8'h8E;
      default: unused_bits = 8'h00;
    endcase
  endfunction : unused_bits
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_read_idle: assert property (!rd_q |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  chk_unused_zero: assert property (rd_q |->
    (rdata_o & unused_bits(ra_q)) == 8'h00)
    else $error("unimplemented bit read as one");
  chk_flags_held: assert property (rd_q && ra_q == 3'h2 &&
    !$past(en_q) && !$past(en_q, 2) |-> rdata_o[3:0] == 4'h0)
    else $error("flag set while module disabled");
  chk_irq_masked: assert property ((ie_q == 4'h0) [*4] |-> !irq_o)
    else $error("interrupt with all enables clear");
  chk_idle_hold: assert property ((!en_q) [*4] |->
    $stable(pulse_counter_o) && !irq_o)
    else $error("disabled module is active");
  // a disable clears the timer, so only an enabled module must hold still
  chk_reserved_src: assert property ((cs_q == 2'h3 && en_q) [*8] |->
    $stable(pulse_counter_o))
    else $error("timer moved on reserved source");
  chk_load_once: assert property (reload_event_o |->
    ##1 !reload_event_o)
    else $error("second load right after a load");
  chk_load_copy: assert property (reload_event_o |->
    output_control_o == $past(buffered_output_control_bit_i))
    else $error("output control not loaded with the others");
  chk_reset_clear: assert property ($fell(rst_i) |->
    pulse_counter_o == 16'h0000 && !irq_o && !pwm_o)
    else $error("outputs not cleared by reset");
endmodule : pwmcr_properties

bind pwmcr_top pwmcr_properties u_pwmcr_properties (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .buffered_output_control_bit_i(buffered_output_control_bit_i),
  .pwm_o(pwm_o),
  .irq_o(irq_o),
  .reload_event_o(reload_event_o),
  .output_control_o(output_control_o),
  .pulse_counter_o(pulse_counter_o)
);

/* dv/tb_pwm16_control_registers.sv */
// self-checking bench for the pwm control register set
module tb_pwm16_control_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  addr_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        sleep_i = 1'b0;
  logic        ocb = 1'b0;
  logic        ce = 1'b1;
  logic        pwm_o, offset_event_o;
  logic [15:0] ph = 16'h0000;
  logic [15:0] dc = 16'h0000;
  logic [15:0] ofs = 16'h0000;
  logic [7:0]  rdata_o;
  logic [7:0]  d;
  logic [15:0] c0;
  logic [15:0] pulse_counter_o;
  logic        irq_o, output_control_o, reload_event_o;
  logic        so, hf, lf, r1, r2, o1, o2;
  int          err_count = 0;
  int          total_checks = 0;
  int          reload_seen = 0;
  int          offset_seen = 0;
  logic [2:0]  ps_tab [6] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3};
  logic [1:0]  cs_tab [6] = '{2'h0, 2'h3, 2'h0, 2'h2, 2'h1, 2'h0};
  logic        sl_tab [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [15:0] ex_tab [6] = '{16'h10, 16'h0, 16'h0, 16'h8, 16'h4, 16'h2};

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (reload_event_o === 1'b1) reload_seen++;
  always @(posedge clk_i) if (offset_event_o === 1'b1) offset_seen++;

  pwmcr_peer_model peer (.clk_i(clk_i), .sys_osc_o(so), .hf_osc_o(hf),
    .lf_osc_o(lf), .first_reload_o(r1), .second_reload_o(r2),
    .first_offset_o(o1), .second_offset_o(o2));

  pwmcr_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .system_osc_clock_i(so),
    .high_freq_internal_osc_i(hf), .low_freq_internal_osc_i(lf),
    .sleep_i(sleep_i), .phase_buf_i(ph), .duty_buf_i(dc),
    .offset_buf_i(ofs), .buffered_output_control_bit_i(ocb),
    .first_module_reload_event_i(r1), .second_module_reload_event_i(r2),
    .first_module_offset_event_i(o1), .second_module_offset_event_i(o2),
    .pwm_o(pwm_o), .irq_o(irq_o), .reload_event_o(reload_event_o),
    .offset_event_o(offset_event_o), .output_control_o(output_control_o),
    .pulse_counter_o(pulse_counter_o));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic test_reset_values;
    for (int a = 0; a < 6; a++) begin
      rd(a[2:0]);
      check({8'h00, d}, 16'h0000);
    end
    $display("test_reset_values done");
  endtask : test_reset_values
  task automatic test_fields;
    for (int i = 0; i < 8; i++) begin
      wr(3'h3, {1'b1, i[2:0], 2'h3, i[1:0]});
      rd(3'h3);
      check({8'h00, d}, {9'h0, i[2:0], 2'h0, i[1:0]});
      wr(3'h5, {1'b1, i[1:0], i[2], 3'h7, i[0]});
      rd(3'h5);
      check({8'h00, d}, {9'h0, i[1:0], i[2], 3'h0, i[0]});
      wr(3'h0, {3'h3, i[2], i[1:0], 2'h3});
      rd(3'h0);
      check({8'h00, d}, {10'h0, i[2], i[2:0], 2'h0});
    end
    wr(3'h1, 8'hFF);
    rd(3'h1);
    check({8'h00, d}, 16'h000F);
    wr(3'h4, 8'hFF);
    rd(3'h4);
    check({8'h00, d}, 16'h00C1);
    wr(3'h4, 8'h00);
    rd(3'h4);
    check({8'h00, d}, 16'h0000);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h5, 8'h00);
    $display("test_fields done");
  endtask : test_fields
  task automatic test_irq;
    // reserved source keeps the timer still, so no match can set a flag
    wr(3'h3, 8'h03);
    wr(3'h0, 8'h80);
    wr(3'h2, 8'hFF);
    rd(3'h2);
    check({8'h00, d}, 16'h000F);
    wr(3'h1, 8'h04);
    settle(3);
    check({15'h0, irq_o}, 16'h0001);
    wr(3'h1, 8'h00);
    settle(3);
    check({15'h0, irq_o}, 16'h0000);
    wr(3'h0, 8'h00);
    settle(2);
    rd(3'h2);
    check({8'h00, d}, 16'h0000);
    $display("test_irq done");
  endtask : test_irq
  task automatic test_reload;
    wr(3'h6, 8'h03);
    wr(3'h7, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'h80);
    ocb <= 1'b1;
    peer.tick(8);
    check({15'h0, output_control_o}, 16'h0000);
    reload_seen = 0;
    // an arming write at the period count is dropped, so step past it
    if (pulse_counter_o === 16'h0003) peer.tick(1);
    wr(3'h4, 8'h80);
    peer.tick(6);
    check(reload_seen[15:0], 16'h0001);
    check({15'h0, output_control_o}, 16'h0001);
    rd(3'h4);
    check({8'h00, d}, 16'h0000);
    rd(3'h2);
    check({15'h0, d[0]}, 16'h0001);
    ocb <= 1'b0;
    reload_seen = 0;
    if (pulse_counter_o === 16'h0003) peer.tick(1);
    wr(3'h4, 8'hC1);
    peer.tick(8);
    peer.fire(4'h8);
    peer.tick(8);
    check(reload_seen[15:0], 16'h0000);
    peer.fire(4'h4);
    peer.tick(6);
    check(reload_seen[15:0], 16'h0001);
    check({15'h0, output_control_o}, 16'h0000);
    rd(3'h4);
    check({8'h00, d}, 16'h0041);
    $display("test_reload done");
  endtask : test_reload
  task automatic test_prescale;
    wr(3'h0, 8'h00);
    wr(3'h6, 8'hFF);
    wr(3'h7, 8'hFF);
    wr(3'h0, 8'h80);
    // divisors only grow, so a leftover prescale count stays in range
    for (int i = 0; i < 6; i++) begin
      wr(3'h3, {1'b0, ps_tab[i], 2'h0, cs_tab[i]});
      sleep_i <= sl_tab[i];
      settle(8);
      c0 = pulse_counter_o;
      peer.tick(16);
      check(pulse_counter_o - c0, ex_tab[i]);
    end
    sleep_i <= 1'b0;
    $display("test_prescale done");
  endtask : test_prescale

  task automatic test_slave;
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h5, 8'h21);
    ofs <= 16'h0002;
    wr(3'h0, 8'h80);
    offset_seen = 0;
    // the unpicked peer must not start the slave timer
    peer.fire(4'h2);
    peer.tick(4);
    check(pulse_counter_o, 16'h0000);
    peer.fire(4'h1);
    peer.tick(4);
    check(pulse_counter_o, 16'h0004);
    check(offset_seen[15:0], 16'h0001);
    wr(3'h0, 8'h00);
    wr(3'h5, 8'h00);
    $display("test_slave done");
  endtask : test_slave
  task automatic test_wave;
    wr(3'h0, 8'h10);
    settle(2);
    check({15'h0, pwm_o}, 16'h0001);
    dc <= 16'h0001;
    wr(3'h6, 8'h03);
    wr(3'h7, 8'h00);
    wr(3'h0, 8'h84);
    peer.tick(4);
    check({15'h0, pwm_o}, 16'h0001);
    rd(3'h0);
    check({8'h00, d}, 16'h00A4);
    // two source edges would move a live timer off zero
    ce <= 1'b0;
    c0 = pulse_counter_o;
    peer.tick(2);
    check(pulse_counter_o, c0);
    ce <= 1'b1;
    wr(3'h0, 8'h88);
    peer.tick(4);
    check({15'h0, pwm_o}, 16'h0000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(3'h0);
    check({8'h00, d}, 16'h0000);
    $display("test_wave done");
  endtask : test_wave

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset_values();
    test_fields();
    test_irq();
    test_reload();
    test_prescale();
    test_slave();
    test_wave();
    report_and_stop();
  end
endmodule : tb_pwm16_control_registers
